// ===== common/csc_cfg.svh
// offsets, field positions, reset values and decode constants of the codec control registers
// Overview of operation
// - writing one to system bit 15 reloads defaults
// - voice_rate_sel bits 14:13 pick voice sampling range
// - voice_clk_en bit 12 gates voice clock
// - voice_pwr_on bit 11 powers voice converter
// - bitstream_mode bit 10 selects one-bit stream
// - system_clock_in_ratio picks clock ratio, halved for DAC when dac_half_rate is set
// - op_mode bits 7:6 choose converter clock sources
// - audio_rate_sel bits 5:4 set word-clock sampling range
// - adc_clk_en bit 3 gates audio ADC clock
// - adc_pwr_on bit 2 powers audio ADC
// - dac_clk_en bit 1 gates DAC clock
// - dac_pwr_on bit 0 powers the DAC
// - adc_dc_filt_en bit 15 enables DC removal
// - bits 14 and 13 invert ADC polarity
// - bits 12 and 11 soft-mute ADC 2, 1
// - adc_out_fmt bits 10:8 select ADC output format
// - dac_gain_sel bit 7 gives 6 dB gain
// - interp_slow bit 6 picks slow roll-off filter
// - dac_half_rate bit 5 runs shaper at 64fs
// - dac_input_route bits 4:3 map inputs to channels
// - dac_in_fmt bits 2:0 select DAC input format
// - format codes decode to eight serial formats
// - route code spreads inputs over six channels
// - start-up loads the system default and the subsystem power-up value and sets mutes
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH

// register addresses on the control port
`define CSC_ADDR_W        7
`define CSC_ADDR_SYS      7'h00
`define CSC_ADDR_SUB      7'h01

// system register fields
`define CSC_SYS_RST_BIT   15
`define CSC_SYS_VRATE_HI  14
`define CSC_SYS_VRATE_LO  13
`define CSC_SYS_VCLK_BIT  12
`define CSC_SYS_VPWR_BIT  11
`define CSC_SYS_BSTR_BIT  10
`define CSC_SYS_RATIO_HI  9
`define CSC_SYS_RATIO_LO  8
`define CSC_SYS_MODE_HI   7
`define CSC_SYS_MODE_LO   6
`define CSC_SYS_ARATE_HI  5
`define CSC_SYS_ARATE_LO  4
`define CSC_SYS_ACLK_BIT  3
`define CSC_SYS_APWR_BIT  2
`define CSC_SYS_DCLK_BIT  1
`define CSC_SYS_DPWR_BIT  0

// subsystem register fields
`define CSC_SUB_DCF_BIT   15
`define CSC_SUB_INV2_BIT  14
`define CSC_SUB_INV1_BIT  13
`define CSC_SUB_MUT2_BIT  12
`define CSC_SUB_MUT1_BIT  11
`define CSC_SUB_AFMT_HI   10
`define CSC_SUB_AFMT_LO   8
`define CSC_SUB_GAIN_BIT  7
`define CSC_SUB_SLOW_BIT  6
`define CSC_SUB_HALF_BIT  5
`define CSC_SUB_ROUTE_HI  4
`define CSC_SUB_ROUTE_LO  3
`define CSC_SUB_DFMT_HI   2
`define CSC_SUB_DFMT_LO   0

// reset values: reload defaults and power-up values
`define CSC_SYS_DEFAULT   16'h101A
`define CSC_SUB_DEFAULT   16'h8000
`define CSC_SUB_STARTUP   16'h9800
`define CSC_SYS_KEEP      16'h7FFF
`define CSC_SUB_KEEP      16'hFFFF
`define CSC_ROUTE_DEFAULT 12'hA50

// clock ratio table, multiples of fs
`define CSC_RATIO_256     10'h100
`define CSC_RATIO_384     10'h180
`define CSC_RATIO_512     10'h200
`define CSC_RATIO_768     10'h300

// noise shaper rate and DAC gain
`define CSC_NS_RATE_FULL  8'h80
`define CSC_NS_RATE_HALF  8'h40
`define CSC_GAIN_HIGH_DB  3'h6
`define CSC_GAIN_LOW_DB   3'h0

// word lengths of the serial formats
`define CSC_BITS_16       5'h10
`define CSC_BITS_20       5'h14
`define CSC_BITS_24       5'h18

`endif

// ===== common/csc_pkg.sv
// types shared by the codec control register files
package csc_pkg;

  // serial data formats of the ADC output and DAC input ports
  typedef enum logic [2:0] {
    CSC_FMT_I2S    = 3'b000,
    CSC_FMT_LSB16  = 3'b001,
    CSC_FMT_LSB20  = 3'b010,
    CSC_FMT_LSB24  = 3'b011,
    CSC_FMT_MSB    = 3'b100,
    CSC_FMT_MC20   = 3'b101,
    CSC_FMT_MC24A  = 3'b110,
    CSC_FMT_MC24B  = 3'b111
  } csc_fmt_t;

  // clock source of a converter
  typedef enum logic [1:0] {
    CSC_SRC_SYSTEM_CLOCK_IN = 2'b00,
    CSC_SRC_ADC_WS = 2'b01,
    CSC_SRC_DAC_WS = 2'b10
  } csc_clk_src_t;

  // operating mode codes
  typedef enum logic [1:0] {
    CSC_MODE_SYS_SYS = 2'b00,
    CSC_MODE_SYS_WS  = 2'b01,
    CSC_MODE_WS_SYS  = 2'b10,
    CSC_MODE_WS_WS   = 2'b11
  } csc_mode_t;

endpackage

// ===== rtl/csc_ctrl_word.sv
// one sixteen-bit control word with write, reload and power-up value
`include "csc_cfg.svh"

module csc_ctrl_word #(
  parameter logic [15:0] STARTUP_VAL = 16'h0000,
  parameter logic [15:0] DEFAULT_VAL = 16'h0000,
  parameter logic [15:0] KEEP_MASK   = 16'hFFFF
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic        reload,
  output logic      [15:0] word_reg
);

  ////////////////////////////////////////////////////////////////////
  // storage: reload beats a write, whole word taken in one edge
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      word_reg <= STARTUP_VAL;            // power-up value
    end else if (reload) begin
      word_reg <= DEFAULT_VAL;
    end else if (wr_en) begin
      word_reg <= wr_data & KEEP_MASK;
    end
  end

  // a plain write lands, masked by KEEP_MASK, on the next edge
  chk_word_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_en && !reload) |=> (word_reg == ($past(wr_data) & KEEP_MASK)))
    else $error("control word did not take the written value");

endmodule

// ===== rtl/csc_fmt_decode.sv
// registered decode of a three-bit serial format code
`include "csc_cfg.svh"

module csc_fmt_decode (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic [2:0]       fmt_code,
  output csc_pkg::csc_fmt_t     fmt_reg,
  output logic      [4:0]       bits_reg,
  output logic                  multi_reg
);

  ////////////////////////////////////////////////////////////////////
  // format, word length and multichannel flag
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fmt_reg   <= csc_pkg::CSC_FMT_I2S;
      bits_reg  <= `CSC_BITS_24;
      multi_reg <= 1'b0;
    end else begin
      fmt_reg   <= csc_pkg::csc_fmt_t'(fmt_code);
      multi_reg <= fmt_code[2] & (fmt_code[1] | fmt_code[0]);
      case (fmt_code)
        3'h1: bits_reg <= `CSC_BITS_16;                     // lsb 16 bit
        3'h2: bits_reg <= `CSC_BITS_20;                     // lsb 20 bit
        3'h5: bits_reg <= `CSC_BITS_20;                     // multichannel 20 bit
        default: bits_reg <= `CSC_BITS_24;                  // all others carry 24
      endcase
    end
  end

  // code 001 gives a sixteen-bit lsb-justified word
  chk_fmt_lsb16: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (fmt_code == 3'h1) |=> (bits_reg == `CSC_BITS_16 && !multi_reg))
    else $error("format 001 not decoded as lsb 16 bit");

endmodule

// ===== rtl/csc_regs_top.sv
// system and converter subsystem control registers of the codec
`include "csc_cfg.svh"

module csc_regs_top (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  // word port from the serial control receiver
  input  wire logic                       reg_wr_stb,
  input  wire logic                       reg_rd_stb,
  input  wire logic [`CSC_ADDR_W-1:0]     reg_addr,
  input  wire logic [15:0]                reg_wr_data,
  output logic      [15:0]                reg_rd_data,
  output logic                            reg_rd_valid,
  output logic                            soft_reset_pulse,
  // voice converter controls
  output logic      [1:0]                 voice_rate_sel,
  output logic                            voice_rate_rsvd,
  output logic                            voice_clk_en,
  output logic                            voice_pwr_on,
  output logic                            voice_softmute,
  // clocking and mode
  output logic                            bitstream_mode,
  output logic      [9:0]                 adc_clk_ratio,
  output logic      [9:0]                 dac_clk_ratio,
  output csc_pkg::csc_clk_src_t           adc_clk_src,
  output csc_pkg::csc_clk_src_t           dac_clk_src,
  output logic      [1:0]                 audio_rate_sel,
  output logic                            audio_rate_active,
  // audio ADC controls
  output logic                            adc_clk_en,
  output logic                            adc_pwr_on,
  output logic                            adc_dc_filt_en,
  output logic                            adc1_invert,
  output logic                            adc2_invert,
  output logic                            adc1_softmute,
  output logic                            adc2_softmute,
  output csc_pkg::csc_fmt_t               adc_out_fmt,
  output logic      [4:0]                 adc_out_bits,
  output logic                            adc_out_multi,
  // DAC controls
  output logic                            dac_clk_en,
  output logic                            dac_pwr_on,
  output logic      [2:0]                 dac_gain_db,
  output logic                            interp_slow,
  output logic                            dac_half_rate,
  output logic      [7:0]                 ns_rate,
  output logic      [11:0]                dac_ch_src,
  output csc_pkg::csc_fmt_t               dac_in_fmt,
  output logic      [4:0]                 dac_in_bits,
  output logic                            dac_in_multi,
  output logic                            dac_mute,
  output logic                            dac_quick_mute
);

  ////////////////////////////////////////////////////////////////////
  // address decode and write strobes
  logic        sys_sel;         // address hits the system register
  logic        sub_sel;         // address hits the subsystem register
  logic        sys_wr;          // write to system register
  logic        sub_wr;          // write to subsystem register
  logic        reload_req;      // write of one to the reset bit
  logic [15:0] sys_reg;         // stored system word
  logic [15:0] sub_reg;         // stored subsystem word
  logic [9:0]  ratio_next;      // ratio from table, shared by ADC and DAC

  always_comb begin
    sys_sel = 1'b0;
    sub_sel = 1'b0;
    if (reg_addr == `CSC_ADDR_SYS) begin
      sys_sel = 1'b1;
    end else if (reg_addr == `CSC_ADDR_SUB) begin
      sub_sel = 1'b1;
    end
  end

  assign sys_wr     = reg_wr_stb & sys_sel;
  assign sub_wr     = reg_wr_stb & sub_sel;
  // only a one in the reset bit reloads; zero there is a normal write
  assign reload_req = sys_wr & reg_wr_data[`CSC_SYS_RST_BIT];

  ////////////////////////////////////////////////////////////////////
  // the two control words
  csc_ctrl_word #(
    .STARTUP_VAL (`CSC_SYS_DEFAULT),
    .DEFAULT_VAL (`CSC_SYS_DEFAULT),
    .KEEP_MASK   (`CSC_SYS_KEEP)
  ) u_sys_word (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .wr_en    (sys_wr),
    .wr_data  (reg_wr_data),
    .reload   (reload_req),
    .word_reg (sys_reg)
  );

  csc_ctrl_word #(
    .STARTUP_VAL (`CSC_SUB_STARTUP),
    .DEFAULT_VAL (`CSC_SUB_DEFAULT),
    .KEEP_MASK   (`CSC_SUB_KEEP)
  ) u_sub_word (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .wr_en    (sub_wr),
    .wr_data  (reg_wr_data),
    .reload   (reload_req),
    .word_reg (sub_reg)
  );

  ////////////////////////////////////////////////////////////////////
  // read port: one cycle after the strobe, unmapped reads as zero
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      reg_rd_valid <= 1'b0;
      reg_rd_data  <= 16'h0000;
    end else begin
      reg_rd_valid <= reg_rd_stb;
      if (!reg_rd_stb) begin
        reg_rd_data <= 16'h0000;
      end else if (sys_sel) begin
        reg_rd_data <= sys_reg;           // bit 15 always reads zero
      end else if (sub_sel) begin
        reg_rd_data <= sub_reg;
      end else begin
        reg_rd_data <= 16'h0000;          // unmapped address
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // reload marker and mutes of the neighbouring registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      soft_reset_pulse <= 1'b0;
      voice_softmute   <= 1'b1;           // muted from start-up
      dac_mute         <= 1'b1;
      dac_quick_mute   <= 1'b1;
    end else begin
      soft_reset_pulse <= reload_req;
      if (reload_req) begin
        voice_softmute <= 1'b0;           // their reload defaults are zero
        dac_mute       <= 1'b0;
        dac_quick_mute <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // voice converter fields
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      voice_rate_sel  <= 2'h0;
      voice_rate_rsvd <= 1'b0;
      voice_clk_en    <= 1'b1;
      voice_pwr_on    <= 1'b0;
    end else begin
      voice_rate_sel  <= sys_reg[`CSC_SYS_VRATE_HI:`CSC_SYS_VRATE_LO];
      voice_rate_rsvd <= &sys_reg[`CSC_SYS_VRATE_HI:`CSC_SYS_VRATE_LO];   // code 11 reserved
      voice_clk_en    <= sys_reg[`CSC_SYS_VCLK_BIT];
      voice_pwr_on    <= sys_reg[`CSC_SYS_VPWR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clock ratio lookup shared by the ADC and DAC sides
  always_comb begin
    case (sys_reg[`CSC_SYS_RATIO_HI:`CSC_SYS_RATIO_LO])
      2'h0: ratio_next = `CSC_RATIO_256;
      2'h1: ratio_next = `CSC_RATIO_384;
      2'h2: ratio_next = `CSC_RATIO_512;
      default: ratio_next = `CSC_RATIO_768;
    endcase
  end

  // ratios, clock sources and sampling range
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      bitstream_mode    <= 1'b0;
      adc_clk_ratio     <= `CSC_RATIO_256;
      dac_clk_ratio     <= `CSC_RATIO_256;
      adc_clk_src       <= csc_pkg::CSC_SRC_SYSTEM_CLOCK_IN;
      dac_clk_src       <= csc_pkg::CSC_SRC_SYSTEM_CLOCK_IN;
      audio_rate_sel    <= 2'h1;
      audio_rate_active <= 1'b0;
    end else begin
      bitstream_mode <= sys_reg[`CSC_SYS_BSTR_BIT];
      adc_clk_ratio  <= ratio_next;
      // the DAC ratio halves when the half-rate bit is set
      if (sub_reg[`CSC_SUB_HALF_BIT]) begin
        dac_clk_ratio <= {1'b0, ratio_next[9:1]};
      end else begin
        dac_clk_ratio <= ratio_next;
      end
      // converter clock sources per operating mode
      case (csc_pkg::csc_mode_t'(sys_reg[`CSC_SYS_MODE_HI:`CSC_SYS_MODE_LO]))
        csc_pkg::CSC_MODE_SYS_SYS: begin
          adc_clk_src <= csc_pkg::CSC_SRC_SYSTEM_CLOCK_IN;
          dac_clk_src <= csc_pkg::CSC_SRC_SYSTEM_CLOCK_IN;
        end
        csc_pkg::CSC_MODE_SYS_WS: begin
          adc_clk_src <= csc_pkg::CSC_SRC_SYSTEM_CLOCK_IN;
          dac_clk_src <= csc_pkg::CSC_SRC_DAC_WS;
        end
        csc_pkg::CSC_MODE_WS_SYS: begin
          adc_clk_src <= csc_pkg::CSC_SRC_ADC_WS;
          dac_clk_src <= csc_pkg::CSC_SRC_SYSTEM_CLOCK_IN;
        end
        default: begin
          adc_clk_src <= csc_pkg::CSC_SRC_DAC_WS;
          dac_clk_src <= csc_pkg::CSC_SRC_DAC_WS;
        end
      endcase
      // range only steers converters running from a word clock
      audio_rate_sel    <= sys_reg[`CSC_SYS_ARATE_HI:`CSC_SYS_ARATE_LO];
      audio_rate_active <= |sys_reg[`CSC_SYS_MODE_HI:`CSC_SYS_MODE_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clock gates and power states
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      adc_clk_en <= 1'b1;
      adc_pwr_on <= 1'b0;
      dac_clk_en <= 1'b1;
      dac_pwr_on <= 1'b0;
    end else begin
      adc_clk_en <= sys_reg[`CSC_SYS_ACLK_BIT];
      adc_pwr_on <= sys_reg[`CSC_SYS_APWR_BIT];
      dac_clk_en <= sys_reg[`CSC_SYS_DCLK_BIT];
      dac_pwr_on <= sys_reg[`CSC_SYS_DPWR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // audio ADC processing controls
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      adc_dc_filt_en <= 1'b1;
      adc2_invert    <= 1'b0;
      adc1_invert    <= 1'b0;
      adc2_softmute  <= 1'b1;
      adc1_softmute  <= 1'b1;
    end else begin
      adc_dc_filt_en <= sub_reg[`CSC_SUB_DCF_BIT];
      adc2_invert    <= sub_reg[`CSC_SUB_INV2_BIT];
      adc1_invert    <= sub_reg[`CSC_SUB_INV1_BIT];
      adc2_softmute  <= sub_reg[`CSC_SUB_MUT2_BIT];
      adc1_softmute  <= sub_reg[`CSC_SUB_MUT1_BIT];
    end
  end

  // ADC output format decode
  csc_fmt_decode u_adc_fmt (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .fmt_code  (sub_reg[`CSC_SUB_AFMT_HI:`CSC_SUB_AFMT_LO]),
    .fmt_reg   (adc_out_fmt),
    .bits_reg  (adc_out_bits),
    .multi_reg (adc_out_multi)
  );

  ////////////////////////////////////////////////////////////////////
  // DAC gain, filter, shaper rate and input routing
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dac_gain_db   <= `CSC_GAIN_LOW_DB;
      interp_slow   <= 1'b0;
      dac_half_rate <= 1'b0;
      ns_rate       <= `CSC_NS_RATE_FULL;
      dac_ch_src    <= `CSC_ROUTE_DEFAULT;     // inputs in pairs, as route code 00
    end else begin
      dac_gain_db   <= sub_reg[`CSC_SUB_GAIN_BIT] ? `CSC_GAIN_HIGH_DB : `CSC_GAIN_LOW_DB;
      interp_slow   <= sub_reg[`CSC_SUB_SLOW_BIT];
      dac_half_rate <= sub_reg[`CSC_SUB_HALF_BIT];
      ns_rate       <= sub_reg[`CSC_SUB_HALF_BIT] ? `CSC_NS_RATE_HALF : `CSC_NS_RATE_FULL;
      // two bits per channel, channel 1 lowest, value is input number minus one
      for (int ch = 0; ch < 6; ch++) begin
        if (sub_reg[`CSC_SUB_ROUTE_HI:`CSC_SUB_ROUTE_LO] == 2'h0) begin
          dac_ch_src[2*ch +: 2] <= 2'(ch / 2);                            // pairs
        end else begin
          dac_ch_src[2*ch +: 2] <= sub_reg[`CSC_SUB_ROUTE_HI:`CSC_SUB_ROUTE_LO] - 2'h1;
        end
      end
    end
  end

  // DAC input format decode
  csc_fmt_decode u_dac_fmt (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .fmt_code  (sub_reg[`CSC_SUB_DFMT_HI:`CSC_SUB_DFMT_LO]),
    .fmt_reg   (dac_in_fmt),
    .bits_reg  (dac_in_bits),
    .multi_reg (dac_in_multi)
  );

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking chk_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  chk_reload_defaults: assert property (reload_req |=>
    (sys_reg == `CSC_SYS_DEFAULT && sub_reg == `CSC_SUB_DEFAULT && soft_reset_pulse))
    else $error("reset bit write did not reload defaults");

  chk_rst_not_kept: assert property (sys_wr |=> !sys_reg[`CSC_SYS_RST_BIT] ##1
    (!dac_mute || !$past(reload_req, 2)))
    else $error("reset request bit was stored");

  chk_zero_no_reload: assert property ((sys_wr && !reg_wr_data[`CSC_SYS_RST_BIT]) |=>
    (!soft_reset_pulse && sys_reg == $past(reg_wr_data)))
    else $error("write of zero to reset bit acted as reset");

  chk_dac_ratio_half: assert property ((sub_reg[`CSC_SUB_HALF_BIT] &&
    sys_reg[`CSC_SYS_RATIO_HI:`CSC_SYS_RATIO_LO] == 2'h3) |=> dac_clk_ratio == `CSC_RATIO_384)
    else $error("halved dac ratio wrong");

  chk_mode_sources: assert property ((sys_reg[`CSC_SYS_MODE_HI:`CSC_SYS_MODE_LO] == 2'h2) |=>
    (adc_clk_src == csc_pkg::CSC_SRC_ADC_WS && dac_clk_src == csc_pkg::CSC_SRC_SYSTEM_CLOCK_IN))
    else $error("mode 10 clock sources wrong");

  chk_write_to_pin: assert property (sub_wr |=> ##1
    (ns_rate == ($past(reg_wr_data[`CSC_SUB_HALF_BIT], 2) ? `CSC_NS_RATE_HALF : `CSC_NS_RATE_FULL)
     || $past(reload_req, 2)))
    else $error("noise shaper rate not following write");

  chk_route_single: assert property ((sub_reg[`CSC_SUB_ROUTE_HI:`CSC_SUB_ROUTE_LO] == 2'h3) |=>
    dac_ch_src == 12'hAAA)
    else $error("route 11 does not feed input 3 to all channels");

  chk_gain_six: assert property (sub_reg[`CSC_SUB_GAIN_BIT] |=> dac_gain_db == `CSC_GAIN_HIGH_DB)
    else $error("dac gain not 6 dB");

  chk_read_answer: assert property ((reg_rd_stb && sys_sel) |=>
    (reg_rd_valid && reg_rd_data == $past(sys_reg) && !reg_rd_data[`CSC_SYS_RST_BIT]))
    else $error("system register read back wrong");

  cov_soft_reset: cover property (reload_req ##1 soft_reset_pulse);
  cov_read_sub: cover property (reg_rd_stb && sub_sel ##1 reg_rd_valid);
  cov_route_change: cover property (sub_wr ##2 $changed(dac_ch_src));

endmodule

// ===== testbench/csc_host_model.sv
// host side model that hands whole control words to the register port
module csc_host_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] reg_rd_data,
  input  wire logic        reg_rd_valid,
  output logic             reg_wr_stb,
  output logic             reg_rd_stb,
  output logic      [6:0]  reg_addr,
  output logic      [15:0] reg_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle lines from time zero
  initial begin
    reg_wr_stb = 1'b0;
    reg_rd_stb = 1'b0;
    reg_addr = 7'h7F;
    reg_wr_data = 16'h0000;
  end

  // one whole word per strobe; released lines show the inverse value
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_stb = 1'b1;
    @(negedge sys_clk);
    reg_wr_stb = 1'b0;
    reg_addr = ~a;
    reg_wr_data = ~d;
  endtask

  // read strobe for one cycle; answer is taken one edge later
  task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic ok);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd_stb = 1'b1;
    @(negedge sys_clk);
    reg_rd_stb = 1'b0;
    reg_addr = ~a;
    ok = reg_rd_valid;
    d = reg_rd_data;
  endtask
endmodule

// ===== testbench/testbench.sv
// self-checking bench of the codec control registers
`include "csc_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst_b, reg_wr_stb, reg_rd_stb, reg_rd_valid, soft_reset_pulse, ok, sp;
  logic [6:0]  reg_addr;
  logic [15:0] reg_wr_data, reg_rd_data, rv;
  logic [1:0]  voice_rate_sel, audio_rate_sel;
  logic        voice_rate_rsvd, voice_clk_en, voice_pwr_on, voice_softmute, bitstream_mode, audio_rate_active;
  logic        adc_clk_en, adc_pwr_on, adc_dc_filt_en, adc1_invert, adc2_invert, adc1_softmute, adc2_softmute;
  logic        adc_out_multi, dac_clk_en, dac_pwr_on, interp_slow, dac_half_rate, dac_in_multi, dac_mute;
  logic        dac_quick_mute;
  logic [9:0]  adc_clk_ratio, dac_clk_ratio;
  logic [4:0]  adc_out_bits, dac_in_bits;
  logic [2:0]  dac_gain_db;
  logic [7:0]  ns_rate;
  logic [11:0] dac_ch_src;
  csc_pkg::csc_clk_src_t adc_clk_src, dac_clk_src;
  csc_pkg::csc_fmt_t     adc_out_fmt, dac_in_fmt;
  int          fail_count = 0;
  int          checks = 0;
  // expected decode tables
  logic [9:0]  rt [4] = '{`CSC_RATIO_256, `CSC_RATIO_384, `CSC_RATIO_512, `CSC_RATIO_768};
  logic [11:0] ct [4] = '{12'hA50, 12'h000, 12'h555, 12'hAAA};
  logic [4:0]  bt [8] = '{5'h18, 5'h10, 5'h14, 5'h18, 5'h18, 5'h14, 5'h18, 5'h18};
  logic [1:0]  asrc [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
  logic [1:0]  dsrc [4] = '{2'h0, 2'h2, 2'h0, 2'h2};

  csc_regs_top u_csc_regs_top (.sys_clk, .rst_b, .reg_wr_stb, .reg_rd_stb, .reg_addr, .reg_wr_data,
    .reg_rd_data, .reg_rd_valid, .soft_reset_pulse, .voice_rate_sel, .voice_rate_rsvd, .voice_clk_en,
    .voice_pwr_on, .voice_softmute, .bitstream_mode, .adc_clk_ratio, .dac_clk_ratio, .adc_clk_src,
    .dac_clk_src, .audio_rate_sel, .audio_rate_active, .adc_clk_en, .adc_pwr_on, .adc_dc_filt_en,
    .adc1_invert, .adc2_invert, .adc1_softmute, .adc2_softmute, .adc_out_fmt, .adc_out_bits,
    .adc_out_multi, .dac_clk_en, .dac_pwr_on, .dac_gain_db, .interp_slow, .dac_half_rate, .ns_rate,
    .dac_ch_src, .dac_in_fmt, .dac_in_bits, .dac_in_multi, .dac_mute, .dac_quick_mute);
  csc_host_model u_csc_host_model (.sys_clk, .reg_rd_data, .reg_rd_valid, .reg_wr_stb, .reg_rd_stb,
    .reg_addr, .reg_wr_data);

  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // compare and count
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // write, catch the reset pulse, then let decoded outputs land
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    u_csc_host_model.wr(a, d);
    sp = soft_reset_pulse;
    @(negedge sys_clk);
  endtask

  // read with valid check
  task automatic rdc(input string n, input logic [6:0] a, input logic [15:0] e);
    u_csc_host_model.rd(a, rv, ok);
    chk({n, " valid"}, 16'(ok), 16'h0001);
    chk(n, rv, e);
  endtask

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    logic [1:0]  i2;
    logic [2:0]  i3;
    logic [15:0] v;
    rst_b = 1'b0;
    sp = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    chk("start mutes", 16'({voice_softmute, dac_mute, dac_quick_mute}), 16'h0007);
    chk("start adc mutes", 16'({adc2_softmute, adc1_softmute}), 16'h0003);
    chk("start route", 16'(dac_ch_src), 16'h0A50);
    rdc("start sys", 7'h00, `CSC_SYS_DEFAULT);
    rdc("start sub", 7'h01, `CSC_SUB_STARTUP);
    $display("test start done");
    // every clock ratio and operating mode code
    for (int i = 0; i < 4; i++) begin
      i2 = 2'(i);
      v = {1'b0, i2, i2[0], i2[1], i2[0], i2, i2, i2, i2[0], i2[1], i2[0], i2[1]};
      wr(7'h00, v);
      rdc("sys word", 7'h00, v);
      chk("voice", 16'({voice_rate_sel, voice_clk_en, voice_pwr_on, bitstream_mode}), 16'(v[14:10]));
      chk("power", 16'({audio_rate_sel, adc_clk_en, adc_pwr_on, dac_clk_en, dac_pwr_on}), 16'(v[5:0]));
      chk("reserved", 16'(voice_rate_rsvd), 16'(i == 3));
      chk("adc ratio", 16'(adc_clk_ratio), 16'(rt[i]));
      chk("adc src", 16'(adc_clk_src), 16'(asrc[i]));
      chk("dac src", 16'(dac_clk_src), 16'(dsrc[i]));
      chk("ws active", 16'(audio_rate_active), 16'(i != 0));
    end
    $display("test system done");
    // every format code and route code
    for (int i = 0; i < 8; i++) begin
      i3 = 3'(i);
      v = {i3[0], i3[1], i3[2], i3[0], i3[1], i3, i3[0], i3[1], i3[0], i3[1:0], i3};
      wr(7'h01, v);
      rdc("sub word", 7'h01, v);
      chk("adc flags", 16'({adc_dc_filt_en, adc2_invert, adc1_invert, adc2_softmute, adc1_softmute}), 16'(v[15:11]));
      chk("filter", 16'({interp_slow, dac_half_rate}), 16'(v[6:5]));
      chk("adc fmt", 16'(adc_out_fmt), 16'(i3));
      chk("dac fmt", 16'(dac_in_fmt), 16'(i3));
      chk("fmt bits", 16'({adc_out_bits, dac_in_bits}), 16'({bt[i], bt[i]}));
      chk("fmt multi", 16'({adc_out_multi, dac_in_multi}), 16'({2{i > 4}}));
      chk("gain", 16'(dac_gain_db), v[7] ? 16'h0006 : 16'h0000);
      chk("shaper", 16'(ns_rate), v[5] ? 16'h0040 : 16'h0080);
      chk("dac ratio", 16'(dac_clk_ratio), 16'(rt[3] >> v[5]));
      chk("route", 16'(dac_ch_src), 16'(ct[v[4:3]]));
    end
    $display("test subsystem done");
    // soft reset, a write of zero, unmapped place
    wr(7'h00, 16'hFFFF);
    chk("reset pulse", 16'(sp), 16'h0001);
    rdc("reload sys", 7'h00, `CSC_SYS_DEFAULT);
    rdc("reload sub", 7'h01, `CSC_SUB_DEFAULT);
    chk("reload ratio", 16'(adc_clk_ratio), 16'(`CSC_RATIO_256));
    chk("reload mutes", 16'({voice_softmute, dac_mute, dac_quick_mute}), 16'h0000);
    wr(7'h01, 16'h1234);
    wr(7'h00, 16'h0000);
    chk("no pulse", 16'(sp), 16'h0000);
    rdc("sub kept", 7'h01, 16'h1234);
    wr(7'h02, 16'hFFFF);
    rdc("unmapped", 7'h02, 16'h0000);
    rdc("sys zero", 7'h00, 16'h0000);
    $display("test reload done");
    complete_run();
  end
endmodule
